// ---- rtl/jcp_top.v ----
`timescale 1ns/1ns
`include "jcp_regs.vh"

module jcp_top #(
	parameter PINS = 8
) (
	input wire sys_clk,
	input wire reset_n,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	output reg tdo,
	output reg tdo_oe,
	input wire chip_enable_n,
	input wire config_restart_n,
	input wire chip_reset_n,
	input wire global_oe,
	output reg config_done_flag_out,
	output reg config_done_flag_oe,
	output reg error_status_out,
	output reg error_status_oe,
	output reg chain_enable_out_n,
	output wire [`JCP_BYTE_LEN-1:0] cfg_data,
	output wire cfg_valid,
	input wire cfg_ready,
	input wire cfg_ok,
	input wire cfg_err,
	input wire [PINS-1:0] pin_in,
	output reg [PINS-1:0] pin_out,
	output reg [PINS-1:0] pin_oe,
	input wire [PINS-1:0] core_out,
	input wire [PINS-1:0] core_oe
);
	// ==========================================
	// Controller states, one-hot
	localparam [15:0] S_RESET = 16'h0001;
	localparam [15:0] S_IDLE = 16'h0002;
	localparam [15:0] S_SEL_DR = 16'h0004;
	localparam [15:0] S_CAP_DR = 16'h0008;
	localparam [15:0] S_SH_DR = 16'h0010;
	localparam [15:0] S_EX1_DR = 16'h0020;
	localparam [15:0] S_PA_DR = 16'h0040;
	localparam [15:0] S_EX2_DR = 16'h0080;
	localparam [15:0] S_UP_DR = 16'h0100;
	localparam [15:0] S_SEL_IR = 16'h0200;
	localparam [15:0] S_CAP_IR = 16'h0400;
	localparam [15:0] S_SH_IR = 16'h0800;
	localparam [15:0] S_EX1_IR = 16'h1000;
	localparam [15:0] S_PA_IR = 16'h2000;
	localparam [15:0] S_EX2_IR = 16'h4000;
	localparam [15:0] S_UP_IR = 16'h8000;

	// ==========================================
	// Input synchronisation and test clock edges
	wire [`JCP_SY_CTRL+PINS-1:0] sy;
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire trst_s;
	wire [PINS-1:0] pin_s;
	reg tck_d;
	wire tck_rise;
	wire tck_fall;

	jcp_sync #(
		.WIDTH(`JCP_SY_CTRL + PINS),
		.RESET_VAL({{PINS{1'b0}}, `JCP_SY_CTRL_RST})
	) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in({pin_in, global_oe, chip_reset_n, config_restart_n, chip_enable_n,
			trst_n, tdi, tms, tck}),
		.sync_out(sy)
	);

	assign tck_s = sy[`JCP_SY_TCK];
	assign tms_s = sy[`JCP_SY_TMS];
	assign tdi_s = sy[`JCP_SY_TDI];
	assign trst_s = sy[`JCP_SY_TRST];
	assign pin_s = sy[`JCP_SY_CTRL+PINS-1:`JCP_SY_CTRL];

	always @(posedge sys_clk) begin
		if (!reset_n)
			tck_d <= 1'b0;
		else
			tck_d <= tck_s;
	end
	assign tck_rise = tck_s & ~tck_d;
	assign tck_fall = ~tck_s & tck_d;

	// ==========================================
	// Controller
	reg [15:0] state;
	reg [15:0] next_state;

	always @* begin
		case (state)
		S_RESET: next_state = tms_s ? S_RESET : S_IDLE;
		S_IDLE: next_state = tms_s ? S_SEL_DR : S_IDLE;
		S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAP_DR;
		S_CAP_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
		S_SH_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
		S_EX1_DR: next_state = tms_s ? S_UP_DR : S_PA_DR;
		S_PA_DR: next_state = tms_s ? S_EX2_DR : S_PA_DR;
		S_EX2_DR: next_state = tms_s ? S_UP_DR : S_SH_DR;
		S_UP_DR: next_state = tms_s ? S_SEL_DR : S_IDLE;
		S_SEL_IR: next_state = tms_s ? S_RESET : S_CAP_IR;
		S_CAP_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
		S_SH_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
		S_EX1_IR: next_state = tms_s ? S_UP_IR : S_PA_IR;
		S_PA_IR: next_state = tms_s ? S_EX2_IR : S_PA_IR;
		S_EX2_IR: next_state = tms_s ? S_UP_IR : S_SH_IR;
		S_UP_IR: next_state = tms_s ? S_SEL_DR : S_IDLE;
		default: next_state = S_RESET;
		endcase
	end

	// ==========================================
	// Instruction and data registers
	reg [`JCP_IR_LEN-1:0] ir_shift;
	reg [`JCP_IR_LEN-1:0] ir;
	reg bypass_bit;
	reg [PINS-1:0] bsr;
	reg [PINS-1:0] bsr_upd;
	reg [`JCP_BYTE_LEN-1:0] cfg_shift;
	reg [`JCP_BIT_CNT_W-1:0] bit_cnt;
	reg byte_push;
	reg configuring;
	reg done;
	reg err;
	wire ce_s;
	wire restart_s;
	wire sel_bsr;
	wire sel_cfg;
	wire byte_ready;

	assign ce_s = sy[`JCP_SY_CE];
	assign restart_s = sy[`JCP_SY_RESTART];
	// Scan instructions are refused while loading, so a stray test cannot corrupt it
	assign sel_bsr = (ir == `JCP_IR_EXTEST || ir == `JCP_IR_SAMPLE) && !configuring;
	assign sel_cfg = (ir == `JCP_IR_CONFIG) && configuring;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= S_RESET;
			ir_shift <= `JCP_IR_BYPASS;
			ir <= `JCP_IR_BYPASS;
			bypass_bit <= 1'b0;
			bsr <= {PINS{1'b0}};
			bsr_upd <= {PINS{1'b0}};
			cfg_shift <= {`JCP_BYTE_LEN{1'b0}};
			bit_cnt <= {`JCP_BIT_CNT_W{1'b0}};
			byte_push <= 1'b0;
		end else if (!trst_s) begin
			// Level acts without any test clock edge
			state <= S_RESET;
			ir <= `JCP_IR_BYPASS;
			bsr_upd <= {PINS{1'b0}};
			bit_cnt <= {`JCP_BIT_CNT_W{1'b0}};
			byte_push <= 1'b0;
		end else begin
			byte_push <= 1'b0;
			if (tck_rise) begin
				state <= next_state;
				case (state)
				S_RESET: ir <= `JCP_IR_BYPASS;
				S_CAP_IR: ir_shift <= `JCP_IR_CAPTURE;
				S_SH_IR: ir_shift <= {tdi_s, ir_shift[`JCP_IR_LEN-1:1]};
				S_UP_IR: ir <= ir_shift;
				S_CAP_DR: begin
					bypass_bit <= 1'b0;
					bit_cnt <= {`JCP_BIT_CNT_W{1'b0}};
					if (sel_bsr)
						bsr <= pin_s;
				end
				S_SH_DR: begin
					// Single flop echo of TDI for bypass and config
					bypass_bit <= tdi_s;
					if (sel_bsr)
						bsr <= {tdi_s, bsr[PINS-1:1]};
					if (sel_cfg) begin
						cfg_shift <= {tdi_s, cfg_shift[`JCP_BYTE_LEN-1:1]};
						bit_cnt <= bit_cnt + 1'b1;
						byte_push <= (bit_cnt == `JCP_BIT_LAST);
					end
				end
				S_UP_DR: if (sel_bsr) bsr_upd <= bsr;
				default: ;
				endcase
			end
		end
	end

	// ==========================================
	// Serial output, data changes on falling edges only; enable also drops when not shifting
	wire shifting;
	assign shifting = (state == S_SH_DR) || (state == S_SH_IR);

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe <= shifting;
			if (state == S_SH_IR)
				tdo <= ir_shift[0];
			else if (sel_bsr)
				tdo <= bsr[0];
			else
				tdo <= bypass_bit;
		end else if (!shifting) begin
			tdo_oe <= 1'b0;
		end
	end

	// ==========================================
	// Configuration byte buffer
	jcp_fifo #(
		.WIDTH(`JCP_BYTE_LEN)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_data(cfg_shift),
		.in_valid(byte_push),
		.in_ready(byte_ready),
		.out_data(cfg_data),
		.out_valid(cfg_valid),
		.out_ready(cfg_ready)
	);

	// ==========================================
	// Configuration status
	wire start_cfg;
	wire overrun;
	assign start_cfg = tck_rise && trst_s && state == S_UP_IR && ir_shift == `JCP_IR_CONFIG
		&& !ce_s && restart_s && !done;
	// A byte with no room is lost; flagged since the cable cannot be stalled
	assign overrun = byte_push && !byte_ready;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			configuring <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
		end else begin
			if (!restart_s) begin
				configuring <= 1'b0;
				done <= 1'b0;
			end else if (start_cfg) begin
				configuring <= 1'b1;
			end else if (configuring && cfg_ok && !cfg_err) begin
				configuring <= 1'b0;
				done <= 1'b1;
			end
			// Error set wins over a restart clear in the same cycle
			if (configuring && (cfg_err || overrun))
				err <= 1'b1;
			else if (!restart_s || start_cfg)
				err <= 1'b0;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			config_done_flag_out <= 1'b0;
			config_done_flag_oe <= 1'b1;
			error_status_out <= 1'b0;
			error_status_oe <= 1'b0;
			chain_enable_out_n <= 1'b1;
		end else begin
			config_done_flag_out <= 1'b0;
			config_done_flag_oe <= ~done;
			error_status_out <= 1'b0;
			error_status_oe <= err;
			chain_enable_out_n <= ~done;
		end
	end

	// ==========================================
	// User pins
	wire chip_rst_s;
	wire goe_s;
	wire extest_on;
	assign chip_rst_s = sy[`JCP_SY_CHIPRST];
	assign goe_s = sy[`JCP_SY_GOE];
	assign extest_on = (ir == `JCP_IR_EXTEST) && !configuring;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_out <= {PINS{1'b0}};
			pin_oe <= {PINS{1'b0}};
		end else if (configuring) begin
			pin_out <= {PINS{1'b0}};
			pin_oe <= {PINS{1'b0}};
		end else if (extest_on) begin
			// Chip reset and global enable deliberately ignored here
			pin_out <= bsr_upd;
			pin_oe <= {PINS{1'b1}};
		end else if (done && chip_rst_s && goe_s) begin
			pin_out <= core_out;
			pin_oe <= core_oe;
		end else begin
			pin_out <= {PINS{1'b0}};
			pin_oe <= {PINS{1'b0}};
		end
	end
endmodule

// ---- pkg/jcp_regs.vh ----
`ifndef JCP_REGS_VH
`define JCP_REGS_VH

// ==========================================
// Instruction register
`define JCP_IR_LEN 4
`define JCP_IR_EXTEST 4'h0
`define JCP_IR_SAMPLE 4'h5
`define JCP_IR_CONFIG 4'h2
`define JCP_IR_BYPASS 4'hf
// Fixed capture pattern, two low bits 01
`define JCP_IR_CAPTURE 4'h1

// ==========================================
// Configuration byte assembly
`define JCP_BYTE_LEN 8
`define JCP_BIT_CNT_W 3
`define JCP_BIT_LAST 3'h7

// ==========================================
// Input synchroniser lane positions
`define JCP_SY_TCK 0
`define JCP_SY_TMS 1
`define JCP_SY_TDI 2
`define JCP_SY_TRST 3
`define JCP_SY_CE 4
`define JCP_SY_RESTART 5
`define JCP_SY_CHIPRST 6
`define JCP_SY_GOE 7
`define JCP_SY_CTRL 8
// Reset value of the control lanes: active-low inputs idle high, except chip enable which resets low
`define JCP_SY_CTRL_RST 8'h68

`endif

// ---- rtl/jcp_sync.v ----
`timescale 1ns/1ns
// ==========================================
// Two flip-flop synchroniser, one per bit
module jcp_sync #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire sys_clk,
	input wire reset_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			// First stage feeds only the second
			always @(posedge sys_clk) begin
				if (!reset_n) begin
					meta <= RESET_VAL[i];
					stable <= RESET_VAL[i];
				end else begin
					meta <= async_in[i];
					stable <= meta;
				end
			end
			assign sync_out[i] = stable;
		end
	endgenerate
endmodule

// ---- rtl/jcp_fifo.v ----
`timescale 1ns/1ns
// ==========================================
// Two-entry buffer, head and tail registers
module jcp_fifo #(
	parameter WIDTH = 8
) (
	input wire sys_clk,
	input wire reset_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] tail;
	reg tail_valid;
	wire push;
	wire pop;

	// Ready only from a flop, so the writer never sees a combinational path
	assign in_ready = ~tail_valid;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			out_data <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
			tail <= {WIDTH{1'b0}};
			tail_valid <= 1'b0;
		end else if (pop || !out_valid) begin
			if (tail_valid) begin
				out_data <= tail;
				out_valid <= 1'b1;
				tail <= in_data;
				tail_valid <= push;
			end else begin
				out_data <= in_data;
				out_valid <= push;
			end
		end else if (push) begin
			tail <= in_data;
			tail_valid <= 1'b1;
		end
	end
endmodule

// ---- tb/jcp_assertions.sv ----
`timescale 1ns/1ns
`include "jcp_regs.vh"
// ==========================================
// Port checker
module jcp_checker #(
	parameter PINS = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic config_restart_n,
	input wire logic cfg_ready,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic config_done_flag_out,
	input wire logic config_done_flag_oe,
	input wire logic error_status_out,
	input wire logic error_status_oe,
	input wire logic chain_enable_out_n,
	input wire logic [`JCP_BYTE_LEN-1:0] cfg_data,
	input wire logic cfg_valid,
	input wire logic [PINS-1:0] pin_oe
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Long enough for the synchroniser to settle
	sequence s_tck_high;
		(tck && trst_n)[*6];
	endsequence
	sequence s_tck_low;
		(!tck && trst_n)[*8];
	endsequence
	property p_tdo_fall;
		s_tck_high |=> $stable(tdo);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("tdo moved without a falling test clock");
	property p_oe_steady;
		s_tck_low |=> $stable(tdo_oe);
	endproperty
	a_oe_steady: assert property (p_oe_steady)
		else $error("tdo enable moved without a test clock edge");
	property p_trst_hiz;
		(!trst_n)[*6] |-> !tdo_oe;
	endproperty
	a_trst_hiz: assert property (p_trst_hiz)
		else $error("tdo driven during test reset");
	property p_cfg_hold;
		cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("stalled byte lost or changed");
	property p_pins_float;
		cfg_valid |-> pin_oe == '0;
	endproperty
	a_pins_float: assert property (p_pins_float)
		else $error("user pin driven while loading");
	property p_done_chain;
		$fell(config_done_flag_oe) |-> !chain_enable_out_n;
	endproperty
	a_done_chain: assert property (p_done_chain)
		else $error("done released without chain enable");
	property p_restart_clear;
		(!config_restart_n)[*6] |-> !error_status_oe && config_done_flag_oe;
	endproperty
	a_restart_clear: assert property (p_restart_clear)
		else $error("restart did not clear status");
	property p_od_low;
		!config_done_flag_out && !error_status_out;
	endproperty
	a_od_low: assert property (p_od_low)
		else $error("open drain data not low");
endmodule
bind jcp_top jcp_checker #(.PINS(PINS)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.tck(tck), .trst_n(trst_n), .config_restart_n(config_restart_n), .cfg_ready(cfg_ready),
	.tdo(tdo), .tdo_oe(tdo_oe), .config_done_flag_out(config_done_flag_out),
	.config_done_flag_oe(config_done_flag_oe), .error_status_out(error_status_out),
	.error_status_oe(error_status_oe), .chain_enable_out_n(chain_enable_out_n),
	.cfg_data(cfg_data), .cfg_valid(cfg_valid), .pin_oe(pin_oe));

// ---- tb/jcp_host.sv ----
`timescale 1ns/1ns
// ==========================================
// Cable model: clock parks low, inputs idle high as pulled up
module jcp_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b1;
	end
	// Read tdo late in the low phase, well after the device updates it
	task automatic step(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		#62 o = tdo_oe ? tdo : 1'bx;
		tck <= 1'b1;
		#63 tck <= 1'b0;
	endtask
	task automatic scan(input logic ir, input logic [7:0] v, input int n, output logic [7:0] q);
		logic o;
		q = 8'h00;
		step(1'b1, 1'b1, o);
		if (ir) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], o);
			q[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		tdi <= 1'b1;
	endtask
	// Only used outside configuration
	task automatic pulse_trst();
		trst_n <= 1'b0;
		#100 trst_n <= 1'b1;
	endtask
endmodule

// ---- tb/test_jcp_top.sv ----
`timescale 1ns/1ns
module test_jcp_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic chip_enable_n = 1'b0;
	logic config_restart_n = 1'b1;
	logic chip_reset_n = 1'b1;
	logic global_oe = 1'b0;
	logic cfg_ready = 1'b0;
	logic cfg_ok = 1'b0;
	logic cfg_err = 1'b0;
	logic [7:0] pin_in = 8'h5a;
	logic [7:0] core_out = 8'hff;
	logic [7:0] core_oe = 8'hff;
	wire tck, tms, tdi, trst_n, tdo, tdo_oe, done_oe, err_oe, chain_n, cfg_valid;
	wire [7:0] cfg_data;
	wire [7:0] pin_oe;
	wire [7:0] pin_out;
	logic [7:0] q;
	logic o;
	int n_mismatch = 0;
	int total_checks = 0;
	jcp_host h (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
	jcp_top #(.PINS(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .chip_enable_n(chip_enable_n),
		.config_restart_n(config_restart_n), .chip_reset_n(chip_reset_n), .global_oe(global_oe),
		.config_done_flag_out(), .config_done_flag_oe(done_oe), .error_status_out(),
		.error_status_oe(err_oe), .chain_enable_out_n(chain_n), .cfg_data(cfg_data),
		.cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_ok(cfg_ok), .cfg_err(cfg_err),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .core_out(core_out),
		.core_oe(core_oe));
	initial forever #5 sys_clk = ~sys_clk;
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait; the core stalls a cycle before taking
	task automatic take(input logic [7:0] exp);
		int i;
		@(negedge sys_clk);
		for (i = 0; i < 40 && cfg_valid !== 1'b1; i++) @(negedge sys_clk);
		if (i == 40) begin
			n_mismatch++;
			$display("ERROR %0t no config byte offered", $time);
			results();
		end
		check(cfg_data, exp);
		@(posedge sys_clk) cfg_ready <= 1'b1;
		@(posedge sys_clk) cfg_ready <= 1'b0;
	endtask
	// Abort a load; status must fall back to idle levels
	task automatic restart();
		@(posedge sys_clk) config_restart_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		config_restart_n <= 1'b1;
		repeat (4) @(negedge sys_clk);
		check({6'h0, done_oe, err_oe}, 8'h02);
	endtask
	task automatic test_scan();
		h.scan(1'b1, 8'h05, 4, q);
		check(q, 8'h01);
		h.scan(1'b0, 8'hc3, 8, q);
		check(q, 8'h5a);
		h.scan(1'b1, 8'h00, 4, q);
		@(negedge sys_clk);
		check(pin_out, 8'hc3);
		check(pin_oe, 8'hff);
		$display("test_scan done");
	endtask
	task automatic test_bypass();
		@(posedge sys_clk) chip_reset_n <= 1'b0;
		global_oe <= 1'b1;
		h.scan(1'b1, 8'h0f, 4, q);
		check(q, 8'h01);
		h.scan(1'b0, 8'hb6, 8, q);
		check(q, 8'h6c);
		@(negedge sys_clk);
		check({7'h0, tdo_oe}, 8'h00);
		$display("test_bypass done");
	endtask
	task automatic test_config();
		h.scan(1'b1, 8'h02, 4, q);
		h.scan(1'b0, 8'ha5, 8, q);
		h.scan(1'b0, 8'h3c, 8, q);
		@(negedge sys_clk);
		check(pin_oe, 8'h00);
		check({7'h0, err_oe}, 8'h00);
		h.scan(1'b0, 8'h77, 8, q);
		repeat (4) @(negedge sys_clk);
		check({7'h0, err_oe}, 8'h01);
		take(8'ha5);
		take(8'h3c);
		h.scan(1'b1, 8'h00, 4, q);
		h.scan(1'b0, 8'h96, 8, q);
		check(q, 8'h2c);
		check(pin_oe, 8'h00);
		restart();
		h.scan(1'b1, 8'h02, 4, q);
		h.scan(1'b0, 8'he1, 8, q);
		take(8'he1);
		cfg_err <= 1'b1;
		@(posedge sys_clk) cfg_err <= 1'b0;
		repeat (4) @(negedge sys_clk);
		check({7'h0, err_oe}, 8'h01);
		restart();
		h.scan(1'b1, 8'h02, 4, q);
		@(posedge sys_clk) cfg_ok <= 1'b1;
		@(posedge sys_clk) cfg_ok <= 1'b0;
		repeat (4) @(negedge sys_clk);
		check({6'h0, done_oe, chain_n}, 8'h00);
		@(posedge sys_clk) chip_reset_n <= 1'b1;
		repeat (4) @(negedge sys_clk);
		check(pin_out, 8'hff);
		check(pin_oe, 8'hff);
		$display("test_config done");
	endtask
	task automatic test_trst();
		h.step(1'b1, 1'b1, o);
		repeat (3) h.step(1'b0, 1'b1, o);
		check({7'h0, tdo_oe}, 8'h01);
		h.pulse_trst();
		check({7'h0, tdo_oe}, 8'h00);
		h.step(1'b0, 1'b1, o);
		h.scan(1'b0, 8'h81, 8, q);
		check(q, 8'h02);
		$display("test_trst done");
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		check({3'h0, tdo_oe, done_oe, err_oe, chain_n, cfg_valid}, 8'h0a);
		$display("test_reset done");
		h.step(1'b0, 1'b1, o);
		test_bypass();
		test_scan();
		test_config();
		test_trst();
		results();
	end
endmodule
